// file: hdl/display_seq_pkg.sv
// Purpose: constants shared by both ends
// Assumes: one 40 MHz clock shared by both ends
// Notes: codes, reset values, timing, offsets
package display_seq_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned SETTLE_MS         = 100;
  localparam int unsigned SETTLE_CYCLES     = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_PULSE_US     = 10;
  localparam int unsigned INIT_PULSE_CYCLES = INIT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAIT_W            = 22;   // holds SETTLE_CYCLES

  // field widths
  localparam int unsigned CONTRAST_W = 8;
  localparam int unsigned LINE_W     = 6;
  localparam int unsigned COL_W      = 7;
  localparam int unsigned PAGE_W     = 3;

  // display commands
  localparam logic [7:0] CMD_DISP_OFF    = 8'hae;
  localparam logic [7:0] CMD_DISP_ON     = 8'haf;
  localparam logic [7:0] CMD_CONTRAST    = 8'h81;
  localparam logic [7:0] CMD_FOLLOW_RAM  = 8'ha4;
  localparam logic [7:0] CMD_ALL_ON      = 8'ha5;
  localparam logic [7:0] CMD_NORMAL      = 8'ha6;
  localparam logic [7:0] CMD_INVERSE     = 8'ha7;
  localparam logic [7:0] CMD_SEG_NORMAL  = 8'ha0;
  localparam logic [7:0] CMD_SEG_REMAP   = 8'ha1;
  localparam logic [7:0] CMD_MUX         = 8'ha8;
  localparam logic [7:0] CMD_SCAN_NORMAL = 8'hc0;
  localparam logic [7:0] CMD_SCAN_REV    = 8'hc8;
  localparam logic [1:0] CMD_START_TOP   = 2'h1;    // 40h..7fh set start line
  localparam logic [4:0] CMD_PAGE_TOP    = 5'h16;   // b0h..b7h set page
  localparam logic [7:0] CLEAR_BYTE      = 8'h00;

  // values after hardware initialisation
  localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 8'h7f;
  localparam logic [LINE_W-1:0]     MUX_RST      = 6'h3f;   // 64 rows
  localparam logic [LINE_W-1:0]     START_RST    = 6'h00;
  localparam logic [COL_W-1:0]      COL_RST      = 7'h00;
  localparam logic [PAGE_W-1:0]     PAGE_RST     = 3'h0;
  localparam logic [COL_W-1:0]      COL_LAST     = 7'h7f;

  // power-up configuration stream
  localparam int unsigned INIT_LEN    = 10;
  localparam int unsigned CLEAR_BYTES = 1024;
  localparam logic [7:0] INIT_SEQ [INIT_LEN] = '{8'ha8, 8'h3f, 8'h81, 8'h7f, 8'ha0,
                                                  8'hc0, 8'h40, 8'ha4, 8'ha6, 8'hb0};

  // controller register map
  localparam logic [3:0] CTRL_OFFS  = 4'h0;
  localparam logic [3:0] STAT_OFFS  = 4'h4;
  localparam int unsigned CTRL_UP   = 0;
  localparam int unsigned CTRL_DOWN = 1;
  localparam int unsigned CTRL_RST  = 2;
  localparam int unsigned CTRL_REFR = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/display_link_if.sv
// Purpose: pins between supply controller and display driver
// Assumes: both ends clocked by the same aclk
// Notes: serial bits are msb first, one bit per ser_valid cycle
`timescale 1ns/100ps
interface display_link_if;
  logic logic_supply_en;   // logic supply switch
  logic panel_supply_en;   // panel high-voltage switch
  logic hw_init_n;         // hardware initialisation, active low
  logic ser_valid;         // one serial bit this cycle
  logic ser_bit;           // serial bit value
  logic ser_dc;            // high: display data, low: command

  modport host (output logic_supply_en, output panel_supply_en, output hw_init_n,
                output ser_valid, output ser_bit, output ser_dc);
  modport device (input logic_supply_en, input panel_supply_en, input hw_init_n,
                  input ser_valid, input ser_bit, input ser_dc);
endinterface

// file: hdl/panel_driver_end.sv
// What this block and its host do
// RL1 - init low: display off, 128x64 mode
// RL2 - normal segment and common address mapping
// RL3 - init clears serial shift register
// RL4 - start line and column counter zero
// RL5 - common scan direction normal
// RL6 - contrast register loads 7Fh
// RL7 - normal display mode, like A4h
// RL8 - host: logic on, off, init, clear, panel
// RL9 - host: panel on, wait 100ms, display on
// RL10 - host: off, panel down, 100ms, logic down
// RL11 - host: logic never off with panel on
// RL12 - host: reset display after noise
// RL13 - host: periodically reissue configuration; here reissued only on a CTRL_REFR request, no timer
// RL14 - init low holds defaults, ignores commands
//
// Purpose: display driver end, holds programmed state
// Assumes: link inputs are synchronous to aclk
// Notes: missing logic supply is treated like a held initialisation
`timescale 1ns/100ps
module panel_driver_end
  import display_seq_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  display_link_if.device                         link,
  output logic                                   display_on,
  output logic                                   panel_lit,
  output logic [display_seq_pkg::CONTRAST_W-1:0] contrast,
  output logic [display_seq_pkg::LINE_W-1:0]     start_line,
  output logic [display_seq_pkg::LINE_W-1:0]     mux_ratio,
  output logic                                   seg_remap,
  output logic                                   com_reverse,
  output logic                                   entire_on,
  output logic                                   inverse,
  output logic [display_seq_pkg::COL_W-1:0]      col_addr,
  output logic [display_seq_pkg::PAGE_W-1:0]     page_addr,
  output logic                                   pix_wr,
  output logic [7:0]                             pix_data,
  output logic [display_seq_pkg::COL_W-1:0]      pix_col,
  output logic [display_seq_pkg::PAGE_W-1:0]     pix_page
);

  // which argument byte the decoder waits for
  typedef enum logic [1:0] {ARG_NONE, ARG_CONTRAST, ARG_MUX} arg_t;

  logic       hold;           // default state forced
  logic [6:0] rx_shift_ff;    // bits of the byte in progress
  logic [2:0] rx_cnt_ff;      // bits taken so far
  logic       byte_done_ff;   // full byte ready, one cycle
  logic [7:0] byte_ff;        // assembled byte
  logic       byte_dc_ff;     // data or command flag of byte
  arg_t       arg_ff;         // pending argument kind
  logic       cmd_byte;       // command byte not an argument
  logic       data_byte;      // display data byte

  logic                  display_on_ff;
  logic                  panel_lit_ff;
  logic [CONTRAST_W-1:0] contrast_ff;
  logic [LINE_W-1:0]     start_line_ff;
  logic [LINE_W-1:0]     mux_ratio_ff;
  logic                  seg_remap_ff;
  logic                  com_reverse_ff;
  logic                  entire_on_ff;
  logic                  inverse_ff;
  logic [COL_W-1:0]      col_ff;
  logic [PAGE_W-1:0]     page_ff;
  logic                  pix_wr_ff;
  logic [7:0]            pix_data_ff;
  logic [COL_W-1:0]      pix_col_ff;
  logic [PAGE_W-1:0]     pix_page_ff;

  // init low, logic supply off or bus reset all force defaults
  // RL14 hold while low
  assign hold = !aresetn || !link.hw_init_n || !link.logic_supply_en;

  assign cmd_byte  = byte_done_ff && !byte_dc_ff && (arg_ff == ARG_NONE);
  assign data_byte = byte_done_ff && byte_dc_ff;

  // serial byte assembly, msb first
  always_ff @(posedge aclk) begin
    if (hold) begin
      // RL3 drop partial bits
      rx_shift_ff  <= 7'h00;
      rx_cnt_ff    <= 3'h0;
      byte_done_ff <= 1'b0;
      byte_ff      <= 8'h00;
      byte_dc_ff   <= 1'b0;
    end else begin
      byte_done_ff <= 1'b0;
      if (link.ser_valid) begin
        rx_shift_ff <= {rx_shift_ff[5:0], link.ser_bit};
        rx_cnt_ff   <= rx_cnt_ff + 3'h1;
        // eighth bit closes the byte
        if (rx_cnt_ff == 3'h7) begin
          byte_done_ff <= 1'b1;
          byte_ff      <= {rx_shift_ff, link.ser_bit};
          byte_dc_ff   <= link.ser_dc;
        end
      end
    end
  end

  // argument tracking for two-byte commands
  always_ff @(posedge aclk) begin
    if (hold) begin
      arg_ff <= ARG_NONE;
    end else if (byte_done_ff && !byte_dc_ff) begin
      if (arg_ff != ARG_NONE) begin
        // argument consumed
        arg_ff <= ARG_NONE;
      end else if (byte_ff == CMD_CONTRAST) begin
        arg_ff <= ARG_CONTRAST;
      end else if (byte_ff == CMD_MUX) begin
        arg_ff <= ARG_MUX;
      end
    end
  end

  // display configuration registers
  always_ff @(posedge aclk) begin
    if (hold) begin
      // RL1 panel off, 64-row mode
      display_on_ff  <= 1'b0;
      mux_ratio_ff   <= MUX_RST;
      // RL2 normal address mapping
      seg_remap_ff   <= 1'b0;
      // RL4 start line zero
      start_line_ff  <= START_RST;
      // RL5 normal common scan
      com_reverse_ff <= 1'b0;
      // RL6 contrast default
      contrast_ff    <= CONTRAST_RST;
      // RL7 follow ram, not inverted
      entire_on_ff   <= 1'b0;
      inverse_ff     <= 1'b0;
    end else if (byte_done_ff && !byte_dc_ff) begin
      case (arg_ff)
        ARG_CONTRAST: begin
          contrast_ff <= byte_ff;
        end
        ARG_MUX: begin
          mux_ratio_ff <= byte_ff[LINE_W-1:0];
        end
        default: begin
          // start line command carries its value in the low bits
          if (byte_ff[7:6] == CMD_START_TOP) begin
            start_line_ff <= byte_ff[LINE_W-1:0];
          end else begin
            case (byte_ff)
              CMD_DISP_OFF:    display_on_ff  <= 1'b0;
              CMD_DISP_ON:     display_on_ff  <= 1'b1;
              CMD_FOLLOW_RAM:  entire_on_ff   <= 1'b0;
              CMD_ALL_ON:      entire_on_ff   <= 1'b1;
              CMD_NORMAL:      inverse_ff     <= 1'b0;
              CMD_INVERSE:     inverse_ff     <= 1'b1;
              CMD_SEG_NORMAL:  seg_remap_ff   <= 1'b0;
              CMD_SEG_REMAP:   seg_remap_ff   <= 1'b1;
              CMD_SCAN_NORMAL: com_reverse_ff <= 1'b0;
              CMD_SCAN_REV:    com_reverse_ff <= 1'b1;
              // unknown codes are ignored
              default:         display_on_ff  <= display_on_ff;
            endcase
          end
        end
      endcase
    end
  end

  // column and page counters
  always_ff @(posedge aclk) begin
    if (hold) begin
      // RL4 column counter zero
      col_ff  <= COL_RST;
      page_ff <= PAGE_RST;
    end else if (data_byte) begin
      // wrap the column into the next page
      col_ff <= col_ff + 7'h01;
      if (col_ff == COL_LAST) begin
        page_ff <= page_ff + 3'h1;
      end
    end else if (cmd_byte && byte_ff[7:3] == CMD_PAGE_TOP) begin
      page_ff <= byte_ff[PAGE_W-1:0];
    end
  end

  // pixel write strobe towards the display memory
  always_ff @(posedge aclk) begin
    if (hold) begin
      pix_wr_ff   <= 1'b0;
      pix_data_ff <= 8'h00;
      pix_col_ff  <= COL_RST;
      pix_page_ff <= PAGE_RST;
    end else begin
      pix_wr_ff <= data_byte;
      if (data_byte) begin
        pix_data_ff <= byte_ff;
        pix_col_ff  <= col_ff;
        pix_page_ff <= page_ff;
      end
    end
  end

  // panel lights only when switched on and supplied
  always_ff @(posedge aclk) begin
    if (hold) begin
      // RL1 panel output off
      panel_lit_ff <= 1'b0;
    end else begin
      panel_lit_ff <= display_on_ff && link.panel_supply_en;
    end
  end

  assign display_on = display_on_ff;
  assign panel_lit = panel_lit_ff;
  assign contrast = contrast_ff;
  assign start_line = start_line_ff;
  assign mux_ratio = mux_ratio_ff;
  assign seg_remap = seg_remap_ff;
  assign com_reverse = com_reverse_ff;
  assign entire_on = entire_on_ff;
  assign inverse = inverse_ff;
  assign col_addr = col_ff;
  assign page_addr = page_ff;
  assign pix_wr = pix_wr_ff;
  assign pix_data = pix_data_ff;
  assign pix_col = pix_col_ff;
  assign pix_page = pix_page_ff;

endmodule

// file: hdl/supply_ctrl_end.sv
// Purpose: controller that sequences supplies and display commands
// Assumes: AXI4-Lite, one access of each kind at a time
// Notes: settle wait is a parameter, short in simulation
`timescale 1ns/100ps
module supply_ctrl_end
  import display_seq_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = display_seq_pkg::SETTLE_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  display_link_if.host     link
);

  typedef enum logic [3:0] {ST_OFF, ST_PULSE, ST_SEND_OFF, ST_INIT, ST_CLEAR, ST_PANEL_UP,
                            ST_SETTLE, ST_SEND_ON, ST_RUN, ST_DN_OFF, ST_DN_PANEL, ST_DN_WAIT} state_t;

  state_t        state_ff;       // sequencer state
  logic [10:0]   idx_ff;         // init table or clear byte index
  logic [WAIT_W-1:0] wait_ff;    // pulse and settle timer
  logic          logic_on_ff;    // logic supply switch
  logic          panel_on_ff;    // panel supply switch
  logic          init_n_ff;      // hardware initialisation pin
  logic          disp_on_ff;     // display-on has been sent
  logic          refresh_ff;     // configuration refresh in progress
  logic          aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [3:0]    awaddr_ff;
  logic [31:0]   wdata_ff;
  logic          wstrb0_ff;
  logic [1:0]    bresp_ff, rresp_ff;
  logic          arready_ff, rvalid_ff;
  logic [31:0]   rdata_ff;
  logic          wr_fire;        // both halves of a write present
  logic [3:0]    req;            // one-cycle control requests
  logic          tx_go;          // sequencer offers a byte
  logic [7:0]    tx_byte;
  logic          tx_dc;
  logic          accept;         // sender takes the offered byte
  logic [7:0]    tx_shift_ff;
  logic [2:0]    tx_cnt_ff;      // bits left after the next one
  logic          tx_busy_ff;
  logic          ser_valid_ff, ser_bit_ff, ser_dc_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign req = (wr_fire && wstrb0_ff && awaddr_ff == CTRL_OFFS) ? wdata_ff[3:0] : 4'h0;

  // write channel: address and data in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0;
      wstrb0_ff  <= 1'b0;
    end else begin
      if (awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff  <= awaddr;
      end else if (!aw_held_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff  <= wdata;
        wstrb0_ff <= wstrb[0];
      end else if (!w_held_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      // status is read-only; other offsets answer slave error
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (awaddr_ff == CTRL_OFFS || awaddr_ff == STAT_OFFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= (araddr == CTRL_OFFS || araddr == STAT_OFFS) ? RESP_OKAY : RESP_SLVERR;
      // control reads zero: its bits are self-clearing requests
      rdata_ff   <= (araddr == STAT_OFFS) ?
                    {24'h0, 4'(state_ff), disp_on_ff, init_n_ff, panel_on_ff, logic_on_ff} : 32'h0;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // byte offered to the sender in each state
  always_comb begin
    tx_go   = 1'b0;
    tx_byte = CMD_DISP_OFF;
    tx_dc   = 1'b0;
    case (state_ff)
      ST_SEND_OFF, ST_DN_OFF: tx_go = 1'b1;
      ST_INIT: begin
        tx_go   = 1'b1;
        tx_byte = INIT_SEQ[idx_ff[3:0]];
      end
      ST_CLEAR: begin
        tx_go   = 1'b1;
        tx_byte = CLEAR_BYTE;
        tx_dc   = 1'b1;
      end
      ST_SEND_ON: begin
        tx_go   = 1'b1;
        tx_byte = CMD_DISP_ON;
      end
      default: tx_go = 1'b0;
    endcase
  end

  assign accept = tx_go && !tx_busy_ff;

  // serialiser, eight cycles per byte, back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift_ff  <= 8'h00;
      tx_cnt_ff    <= 3'h0;
      tx_busy_ff   <= 1'b0;
      ser_valid_ff <= 1'b0;
      ser_bit_ff   <= 1'b0;
      ser_dc_ff    <= 1'b0;
    end else if (accept) begin
      ser_valid_ff <= 1'b1;
      ser_bit_ff   <= tx_byte[7];
      ser_dc_ff    <= tx_dc;
      tx_shift_ff  <= {tx_byte[6:0], 1'b0};
      tx_cnt_ff    <= 3'h6;
      tx_busy_ff   <= 1'b1;
    end else if (tx_busy_ff) begin
      ser_bit_ff  <= tx_shift_ff[7];
      tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      tx_cnt_ff   <= tx_cnt_ff - 3'h1;
      tx_busy_ff  <= (tx_cnt_ff != 3'h0);
    end else begin
      ser_valid_ff <= 1'b0;
    end
  end

  // supply and command sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= ST_OFF;
      idx_ff      <= 11'h0;
      wait_ff     <= '0;
      logic_on_ff <= 1'b0;
      panel_on_ff <= 1'b0;
      init_n_ff   <= 1'b1;
      disp_on_ff  <= 1'b0;
      refresh_ff  <= 1'b0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          // RL8 logic supply first
          if (req[CTRL_UP]) begin
            logic_on_ff <= 1'b1;
            init_n_ff   <= 1'b0;
            wait_ff     <= '0;
            state_ff    <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          wait_ff <= wait_ff + 1'b1;
          if (wait_ff == WAIT_W'(INIT_PULSE_CYCLES - 1)) begin
            init_n_ff <= 1'b1;
            state_ff  <= ST_SEND_OFF;
          end
        end
        ST_SEND_OFF: begin
          // RL8 display off before setup
          if (accept) begin
            disp_on_ff <= 1'b0;
            idx_ff     <= 11'h0;
            state_ff   <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (accept) begin
            idx_ff <= (idx_ff == 11'(INIT_LEN - 1)) ? 11'h0 : idx_ff + 11'h1;
            if (idx_ff == 11'(INIT_LEN - 1)) begin
              state_ff <= refresh_ff ? ST_SEND_ON : ST_CLEAR;
            end
          end
        end
        ST_CLEAR: begin
          if (accept) begin
            idx_ff <= (idx_ff == 11'(CLEAR_BYTES - 1)) ? 11'h0 : idx_ff + 11'h1;
            if (idx_ff == 11'(CLEAR_BYTES - 1)) begin
              state_ff <= panel_on_ff ? ST_SEND_ON : ST_PANEL_UP;
            end
          end
        end
        ST_PANEL_UP: begin
          // RL8 panel only after clear has left
          if (!tx_busy_ff) begin
            panel_on_ff <= 1'b1;
            wait_ff     <= '0;
            state_ff    <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // RL9 settle before display on
          wait_ff <= wait_ff + 1'b1;
          if (wait_ff == WAIT_W'(SETTLE_CYC - 1)) begin
            state_ff <= ST_SEND_ON;
          end
        end
        ST_SEND_ON: begin
          if (accept) begin
            disp_on_ff <= 1'b1;
            refresh_ff <= 1'b0;
            state_ff   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (req[CTRL_DOWN]) begin
            state_ff <= ST_DN_OFF;
          end else if (req[CTRL_RST]) begin
            // RL12 reset then full reinit
            init_n_ff <= 1'b0;
            wait_ff   <= '0;
            state_ff  <= ST_PULSE;
          end else if (req[CTRL_REFR]) begin
            // RL13 reissue configuration
            refresh_ff <= 1'b1;
            idx_ff     <= 11'h0;
            state_ff   <= ST_INIT;
          end
        end
        ST_DN_OFF: begin
          // RL10 display off first
          if (accept) begin
            disp_on_ff <= 1'b0;
            state_ff   <= ST_DN_PANEL;
          end
        end
        ST_DN_PANEL: begin
          if (!tx_busy_ff) begin
            panel_on_ff <= 1'b0;
            wait_ff     <= '0;
            state_ff    <= ST_DN_WAIT;
          end
        end
        ST_DN_WAIT: begin
          // RL11 logic off only after discharge
          wait_ff <= wait_ff + 1'b1;
          if (wait_ff == WAIT_W'(SETTLE_CYC - 1)) begin
            logic_on_ff <= 1'b0;
            state_ff    <= ST_OFF;
          end
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign link.logic_supply_en = logic_on_ff;
  assign link.panel_supply_en = panel_on_ff;
  assign link.hw_init_n = init_n_ff;
  assign link.ser_valid = ser_valid_ff;
  assign link.ser_bit = ser_bit_ff;
  assign link.ser_dc = ser_dc_ff;

endmodule

// file: dv/link_order_asserts.sv
// Purpose: supply and serial ordering checks on the link between the two ends
// Assumes: one aclk, synchronous active-low aresetn
// Notes: waits get one cycle of slack
`timescale 1ns/100ps
module link_order_asserts #(
  parameter int unsigned SETTLE_CYC = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic logic_supply_en,
  input wire logic panel_supply_en,
  input wire logic hw_init_n,
  input wire logic ser_valid,
  input wire logic ser_bit,
  input wire logic ser_dc
);
  localparam int unsigned MIN_WAIT = SETTLE_CYC - 1;  // slack of one cycle
  int unsigned on_cnt_ff;   // cycles since panel switched on, saturating
  int unsigned off_cnt_ff;  // cycles since panel switched off, saturating
  logic [2:0]  bit_cnt_ff;  // position inside the current serial byte
  // saturate so that long idle runs never wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !panel_supply_en) on_cnt_ff <= 0;
    else if (on_cnt_ff < SETTLE_CYC) on_cnt_ff <= on_cnt_ff + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || panel_supply_en) off_cnt_ff <= 0;
    else if (off_cnt_ff < SETTLE_CYC) off_cnt_ff <= off_cnt_ff + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !hw_init_n) bit_cnt_ff <= 3'h0;
    else if (ser_valid) bit_cnt_ff <= bit_cnt_ff + 3'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  panel_needs_logic_a: assert property (panel_supply_en |-> logic_supply_en)
    else $error("panel on, logic off");
  panel_after_init_a: assert property ($rose(panel_supply_en) |-> hw_init_n && !ser_valid && bit_cnt_ff == 3'h0)
    else $error("panel up too early");
  settle_quiet_a: assert property (ser_valid && panel_supply_en |-> on_cnt_ff >= MIN_WAIT)
    else $error("byte before settle");
  discharge_wait_a: assert property ($fell(logic_supply_en) |-> off_cnt_ff >= MIN_WAIT)
    else $error("logic off too early");
  init_quiet_a: assert property (!hw_init_n |-> !ser_valid)
    else $error("bit during init");
  init_pulse_a: assert property ($fell(hw_init_n) |-> !hw_init_n [*8])
    else $error("init pulse short");
  dc_steady_a: assert property (ser_valid && bit_cnt_ff != 3'h0 |-> $stable(ser_dc) && $past(ser_valid))
    else $error("byte broken");
  panel_down_idle_a: assert property ($fell(panel_supply_en) |-> !ser_valid && bit_cnt_ff == 3'h0)
    else $error("panel off mid byte");
endmodule

// file: dv/oled_module_reset_power_sequence_tb.sv
// Purpose: drives the controller over AXI4-Lite and watches the driver end
// Assumes: settle wait shortened to 50 cycles
// Notes: waits poll the status word
`timescale 1ns/100ps
module oled_module_reset_power_sequence_tb;
  import display_seq_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic awready, wready, bvalid, arready, rvalid, display_on, panel_lit, seg_remap, com_reverse, entire_on, inverse;
  logic pix_wr;
  logic [1:0] bresp, rresp;
  logic [7:0] contrast, pix_data;
  logic [5:0] start_line, mux_ratio;
  logic [6:0] col_addr;
  logic [2:0] page_addr;
  int err_count = 0, num_checks = 0, seed = 62, pix_cnt = 0;
  display_link_if link();
  supply_ctrl_end #(.SETTLE_CYC(50)) u_supply_ctrl_end(.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link);
  panel_driver_end u_panel_driver_end(.aclk, .aresetn, .link, .display_on, .panel_lit, .contrast,
    .start_line, .mux_ratio, .seg_remap, .com_reverse, .entire_on, .inverse, .col_addr, .page_addr, .pix_wr,
    .pix_data, .pix_col(), .pix_page());
  link_order_asserts #(.SETTLE_CYC(50)) u_link_order_asserts(.aclk, .aresetn,
    .logic_supply_en(link.logic_supply_en), .panel_supply_en(link.panel_supply_en), .hw_init_n(link.hw_init_n),
    .ser_valid(link.ser_valid), .ser_bit(link.ser_bit), .ser_dc(link.ser_dc));
  initial forever #12.5 aclk = ~aclk;
  // count written pixel bytes
  always @(posedge aclk) if (pix_wr === 1'b1) begin
    pix_cnt++;
    chk(pix_data === CLEAR_BYTE, "pixel");
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk); n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 0;
    chk(n < 100 && bresp === r, "write response");
    if (n >= 100) final_report;
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk); n++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 0; rd_q = rdata;
    chk(n < 100 && rresp === r, "read response");
    if (n >= 100) final_report;
  endtask
  task automatic wait_state(input logic [3:0] s);
    int k = 0;
    do begin rd(STAT_OFFS, RESP_OKAY); k++; end while (rd_q[7:4] !== s && k < 6000);
    if (k >= 6000) begin chk(1'b0, "state timeout"); final_report; end
    // last byte of a state still needs its serial time and decode
    repeat (12) @(posedge aclk);
  endtask
  task automatic defaults;
    chk(display_on === 1'b0 && contrast === CONTRAST_RST && mux_ratio === MUX_RST && start_line === START_RST &&
        seg_remap === 1'b0 && com_reverse === 1'b0 && inverse === 1'b0 && entire_on === 1'b0 &&
        col_addr === COL_RST, "default state");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    defaults;
    for (int i = 0; i < 4; i++) begin
      rd({1'b1, 3'($random(seed))}, RESP_SLVERR);
      wr({1'b1, 3'($random(seed))}, $random(seed), RESP_SLVERR);
    end
    wr(CTRL_OFFS, 32'h2, RESP_OKAY);
    rd(STAT_OFFS, RESP_OKAY);
    chk(rd_q[7:0] === 8'h04, "idle status");
    wr(CTRL_OFFS, 32'h1, RESP_OKAY);
    wait_state(4'h8);
    chk(display_on === 1'b1 && panel_lit === 1'b1 && pix_cnt === CLEAR_BYTES && page_addr === PAGE_RST, "up");
    wr(CTRL_OFFS, 32'h4, RESP_OKAY);
    wait_state(4'h1);
    defaults;
    wait_state(4'h8);
    chk(display_on === 1'b1 && pix_cnt === 2 * CLEAR_BYTES, "display reset");
    wr(CTRL_OFFS, 32'h8, RESP_OKAY);
    wait_state(4'h3);
    wait_state(4'h8);
    chk(display_on === 1'b1 && contrast === CONTRAST_RST && pix_cnt === 2 * CLEAR_BYTES, "refresh");
    wr(CTRL_OFFS, 32'h2, RESP_OKAY);
    wait_state(4'h0);
    chk(display_on === 1'b0 && link.logic_supply_en === 1'b0 && link.panel_supply_en === 1'b0, "down");
    final_report;
  end
endmodule
